// >>> serial_port_defs.vh
`ifndef SERIAL_PORT_DEFS_VH
`define SERIAL_PORT_DEFS_VH

// register offsets on the plain register port
`define ADDR_W             3
`define REG_CONTROL        3'h0
`define REG_DATA           3'h1
`define REG_CLOCK_DIVIDER  3'h2
`define REG_CONFIG         3'h3
`define REG_IRQ_STATUS     3'h4
`define REG_IRQ_MASK       3'h5

// serial_port_control field positions
`define CTL_INT_FLAG       7
`define CTL_WRITE_COLL     6
`define CTL_MODE_FAULT     5
`define CTL_RX_OVERRUN     4
`define CTL_SS_MODE_HI     3
`define CTL_SS_MODE_LO     2
`define CTL_TX_EMPTY       1
`define CTL_PORT_ENABLE    0
`define CTL_RESET          8'h06

// slave select mode codes
`define SS_MODE_3WIRE      2'h0
`define SS_MODE_4WIRE_IN   2'h1

// config register fields
`define CFG_MASTER_ENABLE  0
`define CFG_RESET          8'h00

// divider reset value
`define DIVIDER_RESET      8'h00

// interrupt status / mask bit positions
`define EV_DONE            0
`define EV_MODE_FAULT      1
`define EV_OVERRUN         2
`define EV_WRITE_COLL      3
`define EV_W               4

// bits per transfer
`define FRAME_BITS         4'h8

`endif

// >>> pin_sync.v
`timescale 1ns/100ps
module pin_sync #(
    parameter WIDTH = 1
) (
    input  wire             ref_clk_i,
    input  wire             reset_n_i,
    input  wire [WIDTH-1:0] async_i,
    output wire [WIDTH-1:0] sync_o
);
    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] sync_q;

    // two stages; first stage read only by the second
    always @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            meta_q <= {WIDTH{1'b1}};
            sync_q <= {WIDTH{1'b1}};
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;
endmodule

// >>> serial_port.v
// Contract
// - mode fault set when select low, master enabled and select mode 01
// - mode fault flag cleared only by software writing zero
// - slave overrun set when byte completes with receive buffer unread
// - overrun also raises the port interrupt request
// - overrun flag stays set until software clears it
// - select mode 00: three-wire operation, select pin ignored
// - select mode 01, reset default: four-wire, select always an input
// - read-only transmit empty flag set once byte moves to shifter
//
// Our own choices: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
`include "serial_port_defs.vh"
module serial_port (
    input  wire                ref_clk_i,
    input  wire                reset_n_i,
    input  wire [`ADDR_W-1:0]  reg_addr_i,
    input  wire [7:0]          reg_wdata_i,
    input  wire                reg_write_i,
    input  wire                reg_read_i,
    output reg  [7:0]          reg_rdata_o,
    output wire                irq_o,
    input  wire                sck_i,
    output wire                sck_o,
    output wire                sck_oe_o,
    input  wire                mosi_i,
    output wire                mosi_o,
    output wire                mosi_oe_o,
    input  wire                miso_i,
    output wire                miso_o,
    output wire                miso_oe_o,
    input  wire                slave_select_pin_i,
    output wire                slave_select_pin_o,
    output wire                slave_select_pin_oe_o
);
    // software visible state
    reg        int_flag_q;
    reg        write_coll_q;
    reg        mode_fault_flag_q;
    reg        receive_overrun_flag_q;
    reg [1:0]  slave_select_mode_q;
    reg        port_enable_q;
    reg        master_enable_q;
    reg [7:0]  serial_clock_divider_q;
    reg [`EV_W-1:0] irq_status_q;
    reg [`EV_W-1:0] irq_mask_q;

    // datapath state
    reg [7:0]  tx_buf_q;
    reg        transmit_buffer_empty_q;
    reg [7:0]  rx_buf_q;
    reg        rx_full_q;
    reg [7:0]  shift_q;
    reg [3:0]  bit_cnt_q;
    reg        loaded_q;
    reg        busy_q;
    reg [7:0]  div_cnt_q;
    reg        sck_lvl_q;
    reg        sample_q;
    reg        sck_prev_q;

    wire       sck_s;
    wire       mosi_s;
    wire       miso_s;
    wire       nss_s;

    // all pin inputs cross into the system clock here
    pin_sync #(
        .WIDTH (4)
    ) u_sync (
        .ref_clk_i (ref_clk_i),
        .reset_n_i (reset_n_i),
        .async_i   ({sck_i, mosi_i, miso_i, slave_select_pin_i}),
        .sync_o    ({sck_s, mosi_s, miso_s, nss_s})
    );

    // decoded access strobes
    wire wr_ctl  = reg_write_i && (reg_addr_i == `REG_CONTROL);
    wire wr_data = reg_write_i && (reg_addr_i == `REG_DATA);
    wire wr_div  = reg_write_i && (reg_addr_i == `REG_CLOCK_DIVIDER);
    wire wr_cfg  = reg_write_i && (reg_addr_i == `REG_CONFIG);
    wire wr_mask = reg_write_i && (reg_addr_i == `REG_IRQ_MASK);
    wire rd_data = reg_read_i && (reg_addr_i == `REG_DATA);
    wire rd_stat = reg_read_i && (reg_addr_i == `REG_IRQ_STATUS);

    // mode decode
    wire ss_3wire   = (slave_select_mode_q == `SS_MODE_3WIRE);
    wire ss_4wire   = (slave_select_mode_q == `SS_MODE_4WIRE_IN);
    wire ss_drive   = slave_select_mode_q[1];
    wire is_master  = port_enable_q && master_enable_q;
    // select input only counts in four-wire input mode
    wire slave_sel  = port_enable_q && !master_enable_q &&
                      (ss_4wire ? !nss_s : 1'b1);

    // link clock edges seen by the system clock
    wire sck_rise   = sck_s && !sck_prev_q;
    wire sck_fall   = !sck_s && sck_prev_q;

    // master clock generator tick
    wire div_tick   = busy_q && (div_cnt_q == serial_clock_divider_q);
    wire m_rise     = is_master && div_tick && !sck_lvl_q;
    wire m_fall     = is_master && div_tick && sck_lvl_q;

    // events of this cycle
    wire ev_mode_fault = port_enable_q && master_enable_q &&
                         ss_4wire && !nss_s;
    wire s_last        = slave_sel && sck_rise &&
                         (bit_cnt_q == `FRAME_BITS - 4'h1);
    wire m_last        = m_fall && (bit_cnt_q == `FRAME_BITS - 4'h1);
    wire ev_done       = s_last || m_last;
    wire ev_overrun    = s_last && rx_full_q;
    wire ev_write_coll = wr_data && !transmit_buffer_empty_q;
    wire [`EV_W-1:0] ev_vec;
    assign ev_vec[`EV_DONE]       = ev_done;
    assign ev_vec[`EV_MODE_FAULT] = ev_mode_fault;
    assign ev_vec[`EV_OVERRUN]    = ev_overrun;
    assign ev_vec[`EV_WRITE_COLL] = ev_write_coll;

    // byte moves from transmit buffer into shifter
    wire m_start  = is_master && !busy_q && !transmit_buffer_empty_q &&
                    !ev_mode_fault;
    wire s_load   = slave_sel && !loaded_q && (bit_cnt_q == 4'h0) &&
                    !transmit_buffer_empty_q && !sck_rise && !sck_fall;
    wire tx_take  = m_start || s_load;

    // control register and flags; hardware set wins over software clear
    always @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            int_flag_q             <= 1'b0;
            write_coll_q           <= 1'b0;
            mode_fault_flag_q      <= 1'b0;
            receive_overrun_flag_q <= 1'b0;
            slave_select_mode_q    <= `SS_MODE_4WIRE_IN;
            port_enable_q          <= 1'b0;
        end else begin
            int_flag_q <= (int_flag_q &&
                           !(wr_ctl && !reg_wdata_i[`CTL_INT_FLAG])) ||
                          ev_done || ev_overrun || ev_mode_fault;
            write_coll_q <= (write_coll_q &&
                             !(wr_ctl && !reg_wdata_i[`CTL_WRITE_COLL])) ||
                            ev_write_coll;
            // only a software zero write clears it
            mode_fault_flag_q <= (mode_fault_flag_q &&
                                  !(wr_ctl &&
                                    !reg_wdata_i[`CTL_MODE_FAULT])) ||
                                 ev_mode_fault;
            receive_overrun_flag_q <= (receive_overrun_flag_q &&
                                       !(wr_ctl &&
                                         !reg_wdata_i[`CTL_RX_OVERRUN])) ||
                                      ev_overrun;
            if (wr_ctl) begin
                slave_select_mode_q <=
                    reg_wdata_i[`CTL_SS_MODE_HI:`CTL_SS_MODE_LO];
                port_enable_q <= reg_wdata_i[`CTL_PORT_ENABLE];
            end
        end
    end

    // config, divider and mask registers
    always @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            master_enable_q        <= 1'b0;
            serial_clock_divider_q <= `DIVIDER_RESET;
            irq_mask_q             <= {`EV_W{1'b0}};
        end else begin
            // a collision drops back to slave so two masters never fight
            if (ev_mode_fault)
                master_enable_q <= 1'b0;
            else if (wr_cfg)
                master_enable_q <= reg_wdata_i[`CFG_MASTER_ENABLE];
            if (wr_div)
                serial_clock_divider_q <= reg_wdata_i;
            if (wr_mask)
                irq_mask_q <= reg_wdata_i[`EV_W-1:0];
        end
    end

    // sticky interrupt status, cleared by reading it
    always @(posedge ref_clk_i) begin
        if (!reset_n_i)
            irq_status_q <= {`EV_W{1'b0}};
        else
            irq_status_q <= (rd_stat ? {`EV_W{1'b0}} : irq_status_q) |
                            ev_vec;
    end

    assign irq_o = |(irq_status_q & irq_mask_q);

    // transmit buffer and its empty flag
    always @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            tx_buf_q                <= 8'h00;
            transmit_buffer_empty_q <= 1'b1;
        end else if (!port_enable_q) begin
            transmit_buffer_empty_q <= 1'b1;
        end else if (wr_data && transmit_buffer_empty_q) begin
            tx_buf_q                <= reg_wdata_i;
            transmit_buffer_empty_q <= 1'b0;
        end else if (tx_take) begin
            transmit_buffer_empty_q <= 1'b1;
        end
    end

    // receive buffer; an overrun keeps the unread byte
    always @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            rx_buf_q  <= 8'h00;
            rx_full_q <= 1'b0;
        end else if (ev_done && !rx_full_q) begin
            rx_buf_q  <= s_last ? {shift_q[6:0], mosi_s}
                                : {shift_q[6:0], sample_q};
            rx_full_q <= 1'b1;
        end else if (rd_data) begin
            rx_full_q <= 1'b0;
        end
    end

    // shifter shared by master and slave operation
    always @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            shift_q    <= 8'h00;
            bit_cnt_q  <= 4'h0;
            loaded_q   <= 1'b0;
            busy_q     <= 1'b0;
            div_cnt_q  <= 8'h00;
            sck_lvl_q  <= 1'b0;
            sample_q   <= 1'b0;
            sck_prev_q <= 1'b1;  // matches synchroniser reset, no false rise
        end else begin
            sck_prev_q <= sck_s;
            if (!port_enable_q || (!is_master && !slave_sel)) begin
                // idle or deselected: frame is abandoned
                bit_cnt_q <= 4'h0;
                loaded_q  <= 1'b0;
                busy_q    <= 1'b0;
                sck_lvl_q <= 1'b0;
                div_cnt_q <= 8'h00;
            end else if (is_master) begin
                if (m_start) begin
                    shift_q   <= tx_buf_q;
                    busy_q    <= 1'b1;
                    bit_cnt_q <= 4'h0;
                    div_cnt_q <= 8'h00;
                end else if (busy_q) begin
                    // half period is divider plus one system clocks
                    div_cnt_q <= div_tick ? 8'h00 : div_cnt_q + 8'h01;
                    if (m_rise) begin
                        sck_lvl_q <= 1'b1;
                        sample_q  <= miso_s;
                    end
                    if (m_fall) begin
                        sck_lvl_q <= 1'b0;
                        shift_q   <= {shift_q[6:0], sample_q};
                        bit_cnt_q <= m_last ? 4'h0 : bit_cnt_q + 4'h1;
                        if (m_last)
                            busy_q <= 1'b0;
                    end
                end
            end else begin
                // slave: sample on rising edge of the link clock
                if (s_load) begin
                    shift_q  <= tx_buf_q;
                    loaded_q <= 1'b1;
                end else if (sck_rise) begin
                    shift_q   <= {shift_q[6:0], mosi_s};
                    bit_cnt_q <= s_last ? 4'h0 : bit_cnt_q + 4'h1;
                    if (s_last)
                        loaded_q <= 1'b0;
                end
            end
        end
    end

    // output bit held in a flop, changed on the falling edge
    reg out_bit_q;
    always @(posedge ref_clk_i) begin
        if (!reset_n_i)
            out_bit_q <= 1'b0;
        else if (tx_take)
            out_bit_q <= tx_buf_q[7];
        // master shifts on this same fall, so the next bit is still bit 6
        else if (is_master && m_fall)
            out_bit_q <= shift_q[6];
        else if (slave_sel && sck_fall)
            out_bit_q <= shift_q[7];
    end

    // pin drivers
    assign sck_o     = sck_lvl_q;
    assign sck_oe_o  = is_master;
    assign mosi_o    = out_bit_q;
    assign mosi_oe_o = is_master;
    assign miso_o    = out_bit_q;
    assign miso_oe_o = slave_sel;
    // four-wire single master drives the select pin
    assign slave_select_pin_o    = slave_select_mode_q[0];
    assign slave_select_pin_oe_o = port_enable_q && ss_drive;

    // read data, one cycle after the read strobe
    always @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_read_i) begin
            case (reg_addr_i)
                `REG_CONTROL:
                    reg_rdata_o <= {int_flag_q, write_coll_q,
                                    mode_fault_flag_q,
                                    receive_overrun_flag_q,
                                    slave_select_mode_q,
                                    transmit_buffer_empty_q,
                                    port_enable_q};
                `REG_DATA:          reg_rdata_o <= rx_buf_q;
                `REG_CLOCK_DIVIDER: reg_rdata_o <= serial_clock_divider_q;
                `REG_CONFIG:        reg_rdata_o <= {7'h00, master_enable_q};
                `REG_IRQ_STATUS:    reg_rdata_o <= {4'h0, irq_status_q};
                `REG_IRQ_MASK:      reg_rdata_o <= {4'h0, irq_mask_q};
                default:            reg_rdata_o <= 8'h00;
            endcase
        end else begin
            reg_rdata_o <= 8'h00;
        end
    end
endmodule

// >>> serial_port_sva.sv
`timescale 1ns/100ps
`include "serial_port_defs.vh"
module serial_port_sva (
    input wire               ref_clk_i,
    input wire               reset_n_i,
    input wire [`ADDR_W-1:0] reg_addr_i,
    input wire [7:0]         reg_wdata_i,
    input wire               reg_write_i,
    input wire               reg_read_i,
    input wire [7:0]         reg_rdata_o,
    input wire               irq_o,
    input wire               sck_oe_o,
    input wire               mosi_oe_o,
    input wire               miso_oe_o,
    input wire               slave_select_pin_i,
    input wire               slave_select_pin_o,
    input wire               slave_select_pin_oe_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);
    wire       ctl_wr = reg_write_i && reg_addr_i == `REG_CONTROL;
    reg        ctl_rd_q;
    reg        dat_seen_q;
    reg  [1:0] mode_q;
    reg  [1:0] sticky_q;
    // shadows: select mode, data writes, flags already read back as set
    always @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            ctl_rd_q <= 1'b0;
            dat_seen_q <= 1'b0;
            mode_q <= `SS_MODE_4WIRE_IN;
            sticky_q <= 2'b00;
        end else begin
            ctl_rd_q <= reg_read_i && reg_addr_i == `REG_CONTROL;
            if (reg_write_i && reg_addr_i == `REG_DATA)
                dat_seen_q <= 1'b1;
            if (ctl_wr)
                mode_q <= reg_wdata_i[3:2];
            // a write of zero clears, a write of one keeps
            sticky_q <= (sticky_q | (ctl_rd_q ? reg_rdata_o[5:4] : 2'b00))
                        & (ctl_wr ? reg_wdata_i[5:4] : 2'b11);
        end
    end
    a_fault_stop: assert property (
        (!slave_select_pin_i && mode_q == 2'h1 && sck_oe_o) [*3]
        |-> ##[1:4] !sck_oe_o) else $error("master kept on after collision");
    a_fault_sticky: assert property (
        ctl_rd_q && sticky_q[1] |-> reg_rdata_o[5])
        else $error("mode fault flag lost");
    a_overrun_sticky: assert property (
        ctl_rd_q && sticky_q[0] |-> reg_rdata_o[4])
        else $error("overrun flag lost");
    a_mode_read: assert property (
        ctl_rd_q |-> reg_rdata_o[3:2] == mode_q)
        else $error("select mode readback wrong");
    a_three_wire_pin: assert property (
        ctl_wr && !reg_wdata_i[3] |=> !slave_select_pin_oe_o)
        else $error("select pin driven in input modes");
    a_single_master_pin: assert property (
        ctl_wr && reg_wdata_i[3] && reg_wdata_i[0] |=> slave_select_pin_oe_o
        && slave_select_pin_o == $past(reg_wdata_i[2]))
        else $error("select pin not driven to mode bit");
    a_port_off_quiet: assert property (
        ctl_wr && !reg_wdata_i[0] |=> !(sck_oe_o || mosi_oe_o || miso_oe_o
        || slave_select_pin_oe_o)) else $error("pins driven while off");
    a_txe_no_load: assert property (
        ctl_rd_q && !dat_seen_q |-> reg_rdata_o[1])
        else $error("transmit empty low with no data");
    c_fault: cover property ($fell(sck_oe_o));
    c_irq: cover property ($rose(irq_o));
    c_overrun: cover property (ctl_rd_q && reg_rdata_o[4]);
endmodule
bind serial_port serial_port_sva chk (
    .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i),
    .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o), .irq_o(irq_o),
    .sck_oe_o(sck_oe_o), .mosi_oe_o(mosi_oe_o), .miso_oe_o(miso_oe_o),
    .slave_select_pin_i(slave_select_pin_i),
    .slave_select_pin_o(slave_select_pin_o),
    .slave_select_pin_oe_o(slave_select_pin_oe_o));

// >>> link_partner.sv
`timescale 1ns/100ps
module link_partner (
    input  wire miso_i,
    output reg sck_o,
    output reg mosi_o,
    output reg miso_o,
    output reg nss_o
);
    integer k;
    reg [7:0] rx_q;
    initial begin
        rx_q = 8'h00;
        sck_o = 1'b0;
        mosi_o = 1'b0;
        miso_o = 1'b0;
        nss_o = 1'b1;
    end
    // released line keeps changing so a stale bit never looks valid
    always #17 miso_o = ~miso_o;
    task select(input lvl);
        #5 nss_o = lvl;
    endtask
    // idle-low clock, data changes on fall, 160 ns bit time
    task send_byte(input [7:0] b);
        begin
            // keep every change off the rising system clock edge
            #5;
            nss_o = 1'b0;
            #80;
            for (k = 7; k >= 0; k = k - 1) begin
                mosi_o = b[k];
                #80 sck_o = 1'b1;
                rx_q = {rx_q[6:0], miso_i};
                #80 sck_o = 1'b0;
            end
            #80 nss_o = 1'b1;
            mosi_o = ~mosi_o;
            // deselect gap between frames
            #160;
        end
    endtask
endmodule

// >>> test_serial_port.sv
`timescale 1ns/100ps
`include "serial_port_defs.vh"
module test_serial_port;
    reg                ref_clk_i = 1'b0;
    reg                reset_n_i = 1'b0;
    reg  [`ADDR_W-1:0] reg_addr_i;
    reg  [7:0]         reg_wdata_i;
    reg                reg_write_i = 1'b0;
    reg                reg_read_i = 1'b0;
    wire [7:0]         reg_rdata_o;
    wire               irq_o, sck_o, sck_oe_o, mosi_o, mosi_oe_o;
    wire               miso_o, miso_oe_o, ss_o, ss_oe_o;
    wire               far_sck, far_mosi, far_miso, far_nss;
    integer            n_errors = 0;
    integer            check_count = 0;
    integer            i;
    reg  [7:0]         got;
    reg  [7:0]         mosi_seen;
    reg  [7:0]         row_w [0:5] =
        '{8'h01, 8'h05, 8'h09, 8'h0f, 8'h0c, 8'hf5};
    reg  [7:0]         row_r [0:5] =
        '{8'h03, 8'h07, 8'h0b, 8'h0f, 8'h0e, 8'h07};
    reg  [1:0]         row_p [0:5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h1, 2'h1};
    // each pin is whoever enables it, else the far side
    wire sck_i = sck_oe_o ? sck_o : far_sck;
    wire mosi_i = mosi_oe_o ? mosi_o : far_mosi;
    wire miso_i = miso_oe_o ? miso_o : far_miso;
    wire ss_i = ss_oe_o ? ss_o : far_nss;
    always #10 ref_clk_i = ~ref_clk_i;
    // master out bits as a slave would take them, on each rise
    always @(posedge sck_o)
        mosi_seen <= {mosi_seen[6:0], mosi_o};
    link_partner far (.miso_i(miso_i), .sck_o(far_sck), .mosi_o(far_mosi),
        .miso_o(far_miso), .nss_o(far_nss));
    serial_port dut (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
        .reg_rdata_o(reg_rdata_o), .irq_o(irq_o), .sck_i(sck_i),
        .sck_o(sck_o), .sck_oe_o(sck_oe_o), .mosi_i(mosi_i),
        .mosi_o(mosi_o), .mosi_oe_o(mosi_oe_o), .miso_i(miso_i),
        .miso_o(miso_o), .miso_oe_o(miso_oe_o),
        .slave_select_pin_i(ss_i), .slave_select_pin_o(ss_o),
        .slave_select_pin_oe_o(ss_oe_o));
    task wr(input [2:0] a, input [7:0] d);
        begin
            @(posedge ref_clk_i);
            reg_addr_i <= a;
            reg_wdata_i <= d;
            reg_write_i <= 1'b1;
            @(posedge ref_clk_i);
            reg_write_i <= 1'b0;
        end
    endtask
    task chk(input [7:0] g, input [7:0] e, input string s);
        begin
            check_count = check_count + 1;
            if (g !== e) begin
                n_errors = n_errors + 1;
                $display("BAD t=%0t %s got %h want %h", $time, s, g, e);
            end
        end
    endtask
    // read data stand only in the cycle after the strobe
    task rchk(input [2:0] a, input [7:0] e, input [7:0] m, input string s);
        begin
            @(posedge ref_clk_i);
            reg_addr_i <= a;
            reg_read_i <= 1'b1;
            @(posedge ref_clk_i);
            reg_read_i <= 1'b0;
            @(negedge ref_clk_i);
            got = reg_rdata_o;
            chk(got & m, e, s);
        end
    endtask
    task settle;
        begin
            repeat (6) @(posedge ref_clk_i);
            @(negedge ref_clk_i);
        end
    endtask
    task finish_test;
        begin
            $display("checks %0d mismatches %0d", check_count, n_errors);
            if (n_errors == 0 && check_count > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask
    // whole run is far below this span
    initial begin
        #1000000;
        n_errors = n_errors + 1;
        $display("BAD t=%0t watchdog expired", $time);
        finish_test;
    end
    initial begin
        repeat (20) @(posedge ref_clk_i);
        reset_n_i <= 1'b1;
        rchk(`REG_CONTROL, 8'h06, 8'hff, "ctl reset");
        chk({7'h00, irq_o}, 8'h00, "irq reset");
        $display("test reset done");
        for (i = 0; i < 6; i = i + 1) begin
            wr(`REG_CONTROL, row_w[i]);
            rchk(`REG_CONTROL, row_r[i], 8'hff, "ctl row");
            chk({6'h00, ss_oe_o, ss_o}, {6'h00, row_p[i]}, "pin row");
        end
        rchk(3'h7, 8'h00, 8'hff, "unmapped");
        $display("test modes done");
        wr(`REG_IRQ_MASK, 8'h02);
        wr(`REG_CONFIG, 8'h01);
        wr(`REG_CONTROL, 8'h05);
        far.select(1'b0);
        settle;
        chk({7'h00, irq_o}, 8'h01, "fault irq");
        far.select(1'b1);
        rchk(`REG_CONFIG, 8'h00, 8'h01, "master off");
        rchk(`REG_IRQ_STATUS, 8'h02, 8'h02, "fault event");
        chk({7'h00, irq_o}, 8'h00, "irq cleared");
        rchk(`REG_CONTROL, 8'h20, 8'h20, "fault kept");
        wr(`REG_CONTROL, 8'h05);
        rchk(`REG_CONTROL, 8'h07, 8'hff, "fault cleared");
        $display("test fault done");
        wr(`REG_IRQ_MASK, 8'h04);
        far.send_byte(8'h3c);
        far.send_byte(8'hc3);
        settle;
        chk({7'h00, irq_o}, 8'h01, "overrun irq");
        rchk(`REG_CONTROL, 8'h90, 8'h90, "overrun set");
        rchk(`REG_DATA, 8'h3c, 8'hff, "first byte kept");
        rchk(`REG_CONTROL, 8'h10, 8'h10, "overrun kept");
        rchk(`REG_IRQ_STATUS, 8'h04, 8'h04, "overrun event");
        wr(`REG_CONTROL, 8'h05);
        rchk(`REG_CONTROL, 8'h07, 8'hff, "overrun cleared");
        $display("test overrun done");
        wr(`REG_CONTROL, 8'h04);
        far.send_byte(8'h5a);
        settle;
        rchk(`REG_IRQ_STATUS, 8'h00, 8'hff, "quiet while off");
        wr(`REG_CONTROL, 8'h05);
        far.send_byte(8'h96);
        settle;
        chk({7'h00, irq_o}, 8'h00, "done event masked");
        rchk(`REG_DATA, 8'h96, 8'hff, "byte after enable");
        $display("test enable done");
        wr(`REG_DATA, 8'ha5);
        rchk(`REG_CONTROL, 8'h00, 8'h02, "tx full");
        wr(`REG_DATA, 8'h11);
        rchk(`REG_IRQ_STATUS, 8'h08, 8'h08, "write collision");
        far.send_byte(8'h0f);
        settle;
        chk(far.rx_q, 8'ha5, "slave byte out");
        rchk(`REG_CONTROL, 8'h42, 8'h42, "tx moved");
        rchk(`REG_IRQ_STATUS, 8'h01, 8'h01, "slave done");
        $display("test slave transmit done");
        wr(`REG_CONFIG, 8'h01);
        wr(`REG_CONTROL, 8'h0d);
        wr(`REG_DATA, 8'h3c);
        repeat (40) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        chk(mosi_seen, 8'h3c, "master byte out");
        rchk(`REG_IRQ_STATUS, 8'h01, 8'h01, "master done");
        rchk(`REG_CONTROL, 8'h0f, 8'h2f, "master no fault");
        $display("test master done");
        @(posedge ref_clk_i);
        reset_n_i <= 1'b0;
        repeat (20) @(posedge ref_clk_i);
        reset_n_i <= 1'b1;
        rchk(`REG_CONTROL, 8'h06, 8'hff, "ctl second reset");
        $display("test second reset done");
        finish_test;
    end
endmodule
